/* File: brw_rtc.sv */
`default_nettype none
module brw_rtc #(
   parameter int unsigned PWR_STABLE_CYC = brw_pkg::PWR_STABLE_CYC,
   parameter int unsigned IRQ_PULSE_CYC  = brw_pkg::IRQ_PULSE_CYC,
   parameter int unsigned OSC_PER_TICK   = brw_pkg::OSC_PER_TICK,
   parameter int unsigned RAM_BYTES      = brw_pkg::RAM_BYTES
) (
   input  wire logic        ref_clk_i,
   input  wire logic        nrst_i,
   input  wire logic        ce_n_i,
   input  wire logic        oe_n_i,
   input  wire logic        we_n_i,
   input  wire logic [14:0] addr_in_i,
   input  wire logic [7:0]  data_i,
   input  wire logic        vcc_good_i,
   input  wire logic        osc_clk_i,
   output logic      [7:0]  data_o,
   output logic             data_oe_n_o,
   output logic             irq_out_first_n_o,
   output logic             irq_out_second_o
);
   localparam int CW     = brw_pkg::CNT_W;
   localparam int RAM_AW = $clog2(RAM_BYTES);

   if (RAM_BYTES != 8192 && RAM_BYTES != 32768) begin : g_bad_ram
      $error("RAM_BYTES must be 8192 or 32768");
   end
   if (PWR_STABLE_CYC < 2 || PWR_STABLE_CYC >= (1 << CW) || IRQ_PULSE_CYC < 1 ||
       IRQ_PULSE_CYC >= (1 << CW) || OSC_PER_TICK < 1 || OSC_PER_TICK > 65535) begin : g_bad_cnt
      $error("Counter parameter out of range");
   end

   brw_pkg::brw_state_s s_r;
   brw_pkg::brw_state_s s_nxt;

   logic [7:0] ram [RAM_BYTES];
   logic       ram_we;
   logic [7:0] ram_q;

   function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] maxv,
                                          input logic [7:0] minv);
      logic [8:0] r;
      if (v == maxv) begin
         r = {1'b1, minv};
      end else if (v[3:0] == 4'h9) begin
         r = {1'b0, v[7:4] + 4'h1, 4'h0};
      end else begin
         r = {1'b0, v[7:4], v[3:0] + 4'h1};
      end
      return r;
   endfunction

   function automatic logic [8:0] hour_inc(input logic [7:0] h);
      logic [8:0] r;
      logic [8:0] t;
      r = {1'b0, h};
      if (h[brw_pkg::HOUR_12H_BIT]) begin
         if (h[4:0] == 5'h12) begin
            r[4:0] = 5'h01;
         end else if (h[4:0] == 5'h11) begin
            r[4:0] = 5'h12;
            r[brw_pkg::HOUR_PM_BIT] = ~h[brw_pkg::HOUR_PM_BIT];
            r[8] = h[brw_pkg::HOUR_PM_BIT];
         end else begin
            t = bcd_inc({3'h0, h[4:0]}, 8'h12, 8'h01);
            r[4:0] = t[4:0];
         end
      end else begin
         t = bcd_inc({2'h0, h[5:0]}, 8'h23, 8'h00);
         r[5:0] = t[5:0];
         r[8] = t[8];
      end
      return r;
   endfunction

   function automatic logic [7:0] month_days(input logic [7:0] mon, input logic [7:0] yr);
      logic leap;
      logic [7:0] d;
      leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                   : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
      case (mon)
         8'h02: d = leap ? 8'h29 : 8'h28;
         8'h04, 8'h06, 8'h09, 8'h11: d = 8'h30;
         default: d = 8'h31;
      endcase
      return d;
   endfunction

   function automatic logic [13:0] wd_bin(input logic [7:0] hi, input logic [7:0] lo);
      return ({10'h000, hi[7:4]} * 14'd1000) + ({10'h000, hi[3:0]} * 14'd100) +
             ({10'h000, lo[7:4]} * 14'd10) + {10'h000, lo[3:0]};
   endfunction

   function automatic logic is_alarm_off(input logic [3:0] i);
      return i == brw_pkg::OFF_AMIN || i == brw_pkg::OFF_AHOUR || i == brw_pkg::OFF_ADAY;
   endfunction

   always_comb begin
      logic        ce;
      logic        oe;
      logic        we;
      logic [14:0] addr;
      logic [7:0]  din;
      logic [7:0]  w;
      logic [3:0]  idx;
      logic        is_reg;
      logic        wr_act;
      logic        rd_act;
      logic        wr_end;
      logic        rd_start;
      logic        tick;
      logic        carry;
      logic        sec_roll;
      logic        alarm_hit;
      logic        wd_expire;
      logic        acc_alarm;
      logic        acc_wd;
      logic [8:0]  r;
      logic [13:0] wd_old;
      logic [13:0] wd_new;
      logic [7:0]  cmd;
      logic        alm_int;
      logic        wd_int;
      logic        a_src;
      logic        b_src;
      logic        a_act;
      logic        b_act;
      brw_pkg::brw_time_s t;
      ce = 1'b0; oe = 1'b0; we = 1'b0; addr = '0; din = '0; w = '0; idx = '0; is_reg = 1'b0;
      wr_act = 1'b0; rd_act = 1'b0; wr_end = 1'b0; rd_start = 1'b0; tick = 1'b0; carry = 1'b0;
      sec_roll = 1'b0; alarm_hit = 1'b0; wd_expire = 1'b0; acc_alarm = 1'b0; acc_wd = 1'b0;
      r = '0; wd_old = '0; wd_new = '0; cmd = '0; alm_int = 1'b0; wd_int = 1'b0;
      a_src = 1'b0; b_src = 1'b0; a_act = 1'b0; b_act = 1'b0; t = s_r.tm;
      s_nxt = s_r;
      ram_we = 1'b0;

      // Every input except nrst_i is asynchronous to ref_clk_i and passes two flip-flops first.
      s_nxt.ce_n_sy = {s_r.ce_n_sy[0], ce_n_i};
      s_nxt.oe_n_sy = {s_r.oe_n_sy[0], oe_n_i};
      s_nxt.we_n_sy = {s_r.we_n_sy[0], we_n_i};
      s_nxt.vcc_sy  = {s_r.vcc_sy[0], vcc_good_i};
      s_nxt.osc_sy  = {s_r.osc_sy[1:0], osc_clk_i};
      s_nxt.addr_sy = {s_r.addr_sy[0], addr_in_i};
      s_nxt.data_sy = {s_r.data_sy[0], data_i};
      ce   = ~s_r.ce_n_sy[1];
      oe   = ~s_r.oe_n_sy[1];
      we   = ~s_r.we_n_sy[1];
      addr = s_r.addr_sy[1];
      din  = s_r.data_sy[1];

      // Supply gate: any dropout restarts the full stability wait.
      if (!s_r.vcc_sy[1]) begin
         s_nxt.pwr_cnt = '0;
         s_nxt.bus_en  = 1'b0;
      end else if (!s_r.bus_en) begin
         if (s_r.pwr_cnt == CW'(PWR_STABLE_CYC - 1)) begin
            s_nxt.bus_en = 1'b1;
         end else begin
            s_nxt.pwr_cnt = s_r.pwr_cnt + CW'(1);
         end
      end

      is_reg   = addr < 15'(brw_pkg::NUM_REGS);
      idx      = addr[3:0];
      wr_act   = s_r.bus_en & ce & we;
      rd_act   = s_r.bus_en & ce & oe & ~we;
      wr_end   = s_r.wr_d & ~(ce & we) & s_r.bus_en;
      rd_start = rd_act & ~s_r.rd_d;
      s_nxt.wr_d = wr_act;
      s_nxt.rd_d = rd_act;
      acc_alarm  = (wr_end | rd_start) & is_reg & is_alarm_off(idx);
      acc_wd     = (wr_end | rd_start) & is_reg & (idx == brw_pkg::OFF_WDLO || idx == brw_pkg::OFF_WDHI);

      // The oscillator is far slower than ref_clk_i, so edge counting is exact.
      if (s_r.osc_sy[1] & ~s_r.osc_sy[2]) begin
         if (s_r.osc_cnt == 16'(OSC_PER_TICK - 1)) begin
            s_nxt.osc_cnt = '0;
            tick = ~s_r.ext[brw_pkg::OFF_MONTH][brw_pkg::MONTH_STOP_BIT];
         end else begin
            s_nxt.osc_cnt = s_r.osc_cnt + 16'h0001;
         end
      end

      // Internal counters advance on every tick whatever transfer-enable says.
      if (tick) begin
         r = bcd_inc(t.hund, 8'h99, 8'h00);
         t.hund = r[7:0];
         carry = r[8];
         if (carry) begin
            r = bcd_inc(t.sec, 8'h59, 8'h00);
            t.sec = r[7:0];
            carry = r[8];
            sec_roll = r[8];
         end
         if (carry) begin
            r = bcd_inc(t.min, 8'h59, 8'h00);
            t.min = r[7:0];
            carry = r[8];
         end
         if (carry) begin
            r = hour_inc(t.hour);
            t.hour = r[7:0];
            carry = r[8];
         end
         if (carry) begin
            r = bcd_inc(t.dow, 8'h07, 8'h01);
            t.dow = r[7:0];
            r = bcd_inc(t.date, month_days(t.month, t.year), 8'h01);
            t.date = r[7:0];
            carry = r[8];
         end
         if (carry) begin
            r = bcd_inc(t.month, 8'h12, 8'h01);
            t.month = r[7:0];
            carry = r[8];
         end
         if (carry) begin
            r = bcd_inc(t.year, 8'h99, 8'h00);
            t.year = r[7:0];
         end
         s_nxt.tm = t;
         // All visible copies load from the same incremented snapshot.
         if (s_r.ext[brw_pkg::OFF_CMD][brw_pkg::CMD_TE_BIT]) begin
            s_nxt.ext[brw_pkg::OFF_HUND]  = t.hund;
            s_nxt.ext[brw_pkg::OFF_SEC]   = t.sec;
            s_nxt.ext[brw_pkg::OFF_MIN]   = t.min;
            s_nxt.ext[brw_pkg::OFF_HOUR]  = t.hour;
            s_nxt.ext[brw_pkg::OFF_DOW]   = t.dow;
            s_nxt.ext[brw_pkg::OFF_DATE]  = t.date;
            s_nxt.ext[brw_pkg::OFF_MONTH] = {s_r.ext[brw_pkg::OFF_MONTH][7:6], t.month[5:0]};
            s_nxt.ext[brw_pkg::OFF_YEAR]  = t.year;
         end
         // Alarm is checked against the live time at each minute boundary.
         alarm_hit = sec_roll &
            (s_r.ext[brw_pkg::OFF_AMIN][brw_pkg::ALARM_MASK_BIT] |
             (t.min[6:0] == s_r.ext[brw_pkg::OFF_AMIN][6:0])) &
            (s_r.ext[brw_pkg::OFF_AHOUR][brw_pkg::ALARM_MASK_BIT] |
             (t.hour[6:0] == s_r.ext[brw_pkg::OFF_AHOUR][6:0])) &
            (s_r.ext[brw_pkg::OFF_ADAY][brw_pkg::ALARM_MASK_BIT] |
             (t.dow[2:0] == s_r.ext[brw_pkg::OFF_ADAY][2:0]));
      end

      wd_old    = wd_bin(s_r.ext[brw_pkg::OFF_WDHI], s_r.ext[brw_pkg::OFF_WDLO]);
      wd_expire = tick & (wd_old != 14'h0000) & (s_r.wd_cnt <= 14'h0001);
      if (tick && wd_old != 14'h0000) begin
         s_nxt.wd_cnt = wd_expire ? wd_old : s_r.wd_cnt - 14'h0001;
      end

      // A host write lands after the tick update, so it wins for its byte.
      if (wr_end) begin
         w = din & brw_pkg::REG_MASK[idx];
         if (is_reg) begin
            case (idx)
               brw_pkg::OFF_HUND: s_nxt.tm.hund = w;
               brw_pkg::OFF_SEC: s_nxt.tm.sec = w;
               brw_pkg::OFF_MIN: s_nxt.tm.min = w;
               brw_pkg::OFF_HOUR: s_nxt.tm.hour = w;
               brw_pkg::OFF_DOW: s_nxt.tm.dow = w;
               brw_pkg::OFF_DATE: s_nxt.tm.date = w;
               brw_pkg::OFF_MONTH: s_nxt.tm.month = {3'h0, w[4:0]};
               brw_pkg::OFF_YEAR: s_nxt.tm.year = w;
               default: s_nxt.tm = s_nxt.tm;
            endcase
            if (idx == brw_pkg::OFF_CMD) begin
               s_nxt.ext[idx][7:2] = w[7:2];
            end else begin
               s_nxt.ext[idx] = w;
            end
         end else if (addr < 15'(RAM_BYTES)) begin
            ram_we = 1'b1;
         end
      end

      // Flags: an access clears, but an event in the same cycle wins.
      if (acc_alarm) begin
         s_nxt.ext[brw_pkg::OFF_CMD][brw_pkg::CMD_TDF_BIT] = 1'b0;
      end
      if (alarm_hit) begin
         s_nxt.ext[brw_pkg::OFF_CMD][brw_pkg::CMD_TDF_BIT] = 1'b1;
      end
      wd_new = wd_bin(s_nxt.ext[brw_pkg::OFF_WDHI], s_nxt.ext[brw_pkg::OFF_WDLO]);
      if (acc_wd) begin
         s_nxt.wd_cnt = wd_new;
         s_nxt.ext[brw_pkg::OFF_CMD][brw_pkg::CMD_WDF_BIT] = 1'b0;
      end
      if (wd_expire) begin
         s_nxt.ext[brw_pkg::OFF_CMD][brw_pkg::CMD_WDF_BIT] = 1'b1;
      end

      // Interrupt routing, masking, pulse stretching and pin polarity.
      cmd     = s_r.ext[brw_pkg::OFF_CMD];
      alm_int = cmd[brw_pkg::CMD_TDF_BIT] & ~cmd[brw_pkg::CMD_TDM_BIT];
      wd_int  = cmd[brw_pkg::CMD_WDF_BIT] & ~cmd[brw_pkg::CMD_WAM_BIT];
      a_src   = cmd[brw_pkg::CMD_IPSW_BIT] ? alm_int : wd_int;
      b_src   = cmd[brw_pkg::CMD_IPSW_BIT] ? wd_int : alm_int;
      s_nxt.a_src_d = a_src;
      s_nxt.b_src_d = b_src;
      if (a_src && !s_r.a_src_d) begin
         s_nxt.pa_cnt = CW'(IRQ_PULSE_CYC);
      end else if (s_r.pa_cnt != '0) begin
         s_nxt.pa_cnt = s_r.pa_cnt - CW'(1);
      end
      if (b_src && !s_r.b_src_d) begin
         s_nxt.pb_cnt = CW'(IRQ_PULSE_CYC);
      end else if (s_r.pb_cnt != '0) begin
         s_nxt.pb_cnt = s_r.pb_cnt - CW'(1);
      end
      a_act = cmd[brw_pkg::CMD_PULSE_BIT] ? (s_nxt.pa_cnt != '0) : a_src;
      b_act = cmd[brw_pkg::CMD_PULSE_BIT] ? (s_nxt.pb_cnt != '0) : b_src;
      s_nxt.irq_a_n = ~a_act;
      s_nxt.irq_b   = cmd[brw_pkg::CMD_IBH_BIT] ? b_act : ~b_act;

      // Read data is sampled every cycle; drivers drop three cycles after the write strobe falls.
      if (is_reg) begin
         s_nxt.dout = s_r.ext[idx] & brw_pkg::REG_MASK[idx];
      end else if (addr < 15'(RAM_BYTES)) begin
         s_nxt.dout = ram_q;
      end else begin
         s_nxt.dout = 8'h00;
      end
      s_nxt.doe_n = ~rd_act;
   end

   // The array has no reset; its contents survive as nonvolatile storage would.
   assign ram_q = ram[s_r.addr_sy[1][RAM_AW-1:0]];

   always_ff @(posedge ref_clk_i) begin
      if (ram_we) begin
         ram[s_r.addr_sy[1][RAM_AW-1:0]] <= s_r.data_sy[1];
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_r <= brw_pkg::STATE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign data_o            = s_r.dout;
   assign data_oe_n_o       = s_r.doe_n;
   assign irq_out_first_n_o = s_r.irq_a_n;
   assign irq_out_second_o  = s_r.irq_b;
endmodule
`default_nettype wire

/* File: brw_pkg.sv */
`default_nettype none
package brw_pkg;
   localparam int ADDR_W   = 15;
   localparam int DATA_W   = 8;
   localparam int NUM_REGS = 14;
   localparam int CNT_W    = 25;

   localparam logic [3:0] OFF_HUND  = 4'h0;
   localparam logic [3:0] OFF_SEC   = 4'h1;
   localparam logic [3:0] OFF_MIN   = 4'h2;
   localparam logic [3:0] OFF_AMIN  = 4'h3;
   localparam logic [3:0] OFF_HOUR  = 4'h4;
   localparam logic [3:0] OFF_AHOUR = 4'h5;
   localparam logic [3:0] OFF_DOW   = 4'h6;
   localparam logic [3:0] OFF_ADAY  = 4'h7;
   localparam logic [3:0] OFF_DATE  = 4'h8;
   localparam logic [3:0] OFF_MONTH = 4'h9;
   localparam logic [3:0] OFF_YEAR  = 4'hA;
   localparam logic [3:0] OFF_CMD   = 4'hB;
   localparam logic [3:0] OFF_WDLO  = 4'hC;
   localparam logic [3:0] OFF_WDHI  = 4'hD;

   localparam int CMD_TE_BIT    = 7;
   localparam int CMD_IPSW_BIT  = 6;
   localparam int CMD_IBH_BIT   = 5;
   localparam int CMD_PULSE_BIT = 4;
   localparam int CMD_WAM_BIT   = 3;
   localparam int CMD_TDM_BIT   = 2;
   localparam int CMD_WDF_BIT   = 1;
   localparam int CMD_TDF_BIT   = 0;
   localparam int HOUR_12H_BIT  = 6;
   localparam int HOUR_PM_BIT   = 5;
   localparam int MONTH_STOP_BIT = 7;
   localparam int ALARM_MASK_BIT = 7;

   // Bits that are not implemented read as zero.
   localparam logic [13:0][7:0] REG_MASK = {8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hDF, 8'h3F, 8'h87,
                                            8'h07, 8'hFF, 8'h7F, 8'hFF, 8'h7F, 8'h7F, 8'hFF};
   localparam logic [13:0][7:0] REG_RST  = {8'h00, 8'h00, 8'hCC, 8'h00, 8'h01, 8'h01, 8'h00,
                                            8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   localparam int CLK_HZ         = 100_000_000;
   localparam int PWR_STABLE_MS  = 200;
   localparam int PWR_STABLE_CYC = (CLK_HZ / 1000) * PWR_STABLE_MS;
   localparam int IRQ_PULSE_MS   = 3;
   localparam int IRQ_PULSE_CYC  = (CLK_HZ / 1000) * IRQ_PULSE_MS;
   localparam int OSC_PER_TICK   = 100;
   localparam int RAM_BYTES      = 32768;

   typedef struct packed {
      logic [7:0] hund;
      logic [7:0] sec;
      logic [7:0] min;
      logic [7:0] hour;
      logic [7:0] dow;
      logic [7:0] date;
      logic [7:0] month;
      logic [7:0] year;
   } brw_time_s;

   localparam brw_time_s TM_RST = '{hund: 8'h00, sec: 8'h00, min: 8'h00, hour: 8'h00,
                                    dow: 8'h01, date: 8'h01, month: 8'h01, year: 8'h00};

   typedef struct packed {
      logic [1:0]             ce_n_sy;
      logic [1:0]             oe_n_sy;
      logic [1:0]             we_n_sy;
      logic [1:0]             vcc_sy;
      logic [2:0]             osc_sy;
      logic [1:0][14:0]       addr_sy;
      logic [1:0][7:0]        data_sy;
      logic                   wr_d;
      logic                   rd_d;
      logic [CNT_W-1:0]       pwr_cnt;
      logic                   bus_en;
      logic [15:0]            osc_cnt;
      brw_time_s              tm;
      logic [13:0][7:0]       ext;
      logic [13:0]            wd_cnt;
      logic                   a_src_d;
      logic                   b_src_d;
      logic [CNT_W-1:0]       pa_cnt;
      logic [CNT_W-1:0]       pb_cnt;
      logic [7:0]             dout;
      logic                   doe_n;
      logic                   irq_a_n;
      logic                   irq_b;
   } brw_state_s;

   localparam brw_state_s STATE_RST = '{ce_n_sy: 2'h3, oe_n_sy: 2'h3, we_n_sy: 2'h3, tm: TM_RST,
                                        ext: REG_RST, doe_n: 1'b1, irq_a_n: 1'b1, irq_b: 1'b1,
                                        default: '0};
endpackage
`default_nettype wire

/* File: brw_rtc_properties.sv */
`default_nettype none
module brw_rtc_properties #(
   parameter int unsigned PWR_STABLE_CYC = brw_pkg::PWR_STABLE_CYC
) (
   input wire logic        ref_clk_i,
   input wire logic        nrst_i,
   input wire logic        ce_n_i,
   input wire logic        oe_n_i,
   input wire logic        we_n_i,
   input wire logic [14:0] addr_in_i,
   input wire logic        vcc_good_i,
   input wire logic [7:0]  data_o,
   input wire logic        data_oe_n_o,
   input wire logic        irq_out_second_o
);
   logic [31:0] vcc_run_r;
   logic        rd_ok;
   assign rd_ok = !ce_n_i && !oe_n_i && we_n_i;
   // Counts consecutive good-supply cycles; it saturates so the long default window cannot wrap.
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         vcc_run_r <= 32'h0;
      end else if (!vcc_good_i) begin
         vcc_run_r <= 32'h0;
      end else if (vcc_run_r != 32'hFFFFFFFF) begin
         vcc_run_r <= vcc_run_r + 32'h1;
      end
   end
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   a_read_drives: assert property ((rd_ok && vcc_run_r >= PWR_STABLE_CYC + 8) [*4] |-> !data_oe_n_o)
      else $error("read with good supply did not drive the bus");
   a_drive_cause: assert property (!data_oe_n_o |->
      !$past(ce_n_i, 3) && !$past(oe_n_i, 3) && $past(we_n_i, 3))
      else $error("bus driven without a read three cycles before");
   a_write_undrives: assert property (!we_n_i [*4] |-> data_oe_n_o)
      else $error("bus still driven while write strobe low");
   a_select_off: assert property (ce_n_i [*4] |-> data_oe_n_o)
      else $error("bus driven while not selected");
   a_strobe_off: assert property (oe_n_i [*4] |-> data_oe_n_o)
      else $error("bus driven while output strobe high");
   a_supply_off: assert property (!vcc_good_i [*6] |-> data_oe_n_o)
      else $error("bus driven while supply bad");
   a_supply_wait: assert property (!data_oe_n_o |-> $past(vcc_run_r, 6) + 32'd4 >= PWR_STABLE_CYC)
      else $error("bus driven before supply stable window");
   a_ram_stable: assert property ((rd_ok && addr_in_i >= 15'h000E && $stable(addr_in_i)) [*8]
      |-> data_oe_n_o || $stable(data_o))
      else $error("user byte read data changed under a steady address");
   c_read: cover property (rd_ok [*4] ##1 !data_oe_n_o);
   c_write: cover property ((!ce_n_i && !we_n_i) [*4]);
   c_wd_irq: cover property ($fell(irq_out_second_o));
endmodule
bind brw_rtc brw_rtc_properties #(.PWR_STABLE_CYC(PWR_STABLE_CYC)) brw_rtc_properties_inst (
   .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ce_n_i(ce_n_i), .oe_n_i(oe_n_i), .we_n_i(we_n_i),
   .addr_in_i(addr_in_i), .vcc_good_i(vcc_good_i), .data_o(data_o), .data_oe_n_o(data_oe_n_o),
   .irq_out_second_o(irq_out_second_o));
`default_nettype wire

/* File: brw_host.sv */
`default_nettype none
module brw_host (
   input  wire logic        ref_clk_i,
   input  wire logic [7:0]  rd_data_i,
   input  wire logic        rd_oe_n_i,
   output logic             ce_n_o,
   output logic             oe_n_o,
   output logic             we_n_o,
   output logic      [14:0] addr_o,
   output logic      [7:0]  wr_data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      ce_n_o = 1'b1;
      oe_n_o = 1'b1;
      we_n_o = 1'b1;
      addr_o = 15'h0000;
      wr_data_o = 8'h00;
   end
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      ce_n_o <= 1'b0;
      we_n_o <= 1'b0;
      addr_o <= a;
      wr_data_o <= d;
      repeat (5) @(posedge ref_clk_i);
      we_n_o <= 1'b1;
      repeat (3) @(posedge ref_clk_i);
      ce_n_o <= 1'b1;
      // Released data is inverted so a stale value cannot pass for a captured one.
      wr_data_o <= ~d;
      repeat (4) @(posedge ref_clk_i);
   endtask
   task automatic rd(input logic [14:0] a, output logic [7:0] d, output logic ok);
      ok = 1'b0;
      d = 8'h00;
      @(posedge ref_clk_i);
      ce_n_o <= 1'b0;
      oe_n_o <= 1'b0;
      addr_o <= a;
      for (int n = 0; n < 8 && !ok; n++) begin
         @(posedge ref_clk_i);
         if (rd_oe_n_i === 1'b0) begin
            ok = 1'b1;
            d = rd_data_i;
         end
      end
      repeat (6) @(posedge ref_clk_i);
      ce_n_o <= 1'b1;
      oe_n_o <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
   endtask
endmodule
`default_nettype wire

/* File: tb_bytewide_rtc_watchdog_nvram_port.sv */
`default_nettype none
`define BRW_CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin err_total++; \
   $display("wrong value %s expected %h seen %h", what, exp, got); end end
module tb_bytewide_rtc_watchdog_nvram_port;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned PWR = 20;
   localparam int unsigned OPT = 2;
   localparam int unsigned PULSE = 5;
   logic        clk, nrst_n, vcc, osc, ce_n, oe_n, we_n, doe_n, irq_a_n, irq_b, ok;
   logic [14:0] addr;
   logic [7:0]  wdat, rdat, v;
   int          err_total = 0;
   int          total_checks = 0;
   int          a_low = 0;
   brw_rtc #(.PWR_STABLE_CYC(PWR), .IRQ_PULSE_CYC(PULSE), .OSC_PER_TICK(OPT), .RAM_BYTES(8192)) brw_rtc_inst (
      .ref_clk_i(clk), .nrst_i(nrst_n), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .addr_in_i(addr),
      .data_i(wdat), .vcc_good_i(vcc), .osc_clk_i(osc), .data_o(rdat), .data_oe_n_o(doe_n),
      .irq_out_first_n_o(irq_a_n), .irq_out_second_o(irq_b));
   brw_host brw_host_inst (.ref_clk_i(clk), .rd_data_i(rdat), .rd_oe_n_i(doe_n), .ce_n_o(ce_n),
      .oe_n_o(oe_n), .we_n_o(we_n), .addr_o(addr), .wr_data_o(wdat));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Counts cycles with the first interrupt active, so a pulse length can be judged afterwards.
   always @(posedge clk) begin
      if (irq_a_n === 1'b0) begin
         a_low <= a_low + 1;
      end
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      brw_host_inst.wr(a, d);
   endtask
   task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
      brw_host_inst.rd(a, v, ok);
      `BRW_CHK("read data", {1'b1, e}, {ok, v})
   endtask
   // The oscillator only moves inside this task, so every tick count below is exact.
   task automatic ticks(input int n);
      repeat (OPT * n) begin
         repeat (4) @(posedge clk);
         osc <= 1'b1;
         repeat (4) @(posedge clk);
         osc <= 1'b0;
      end
      repeat (8) @(posedge clk);
   endtask
   task automatic t_reset_regs();
      for (int i = 0; i < 14; i++) rd_chk(15'(i), brw_pkg::REG_RST[i]);
      $display("test reset_regs done");
   endtask
   task automatic t_ram();
      wr(15'h000E, 8'hA5);
      wr(15'h1FFF, 8'h3C);
      wr(15'h200E, 8'h77);
      rd_chk(15'h000E, 8'hA5);
      rd_chk(15'h1FFF, 8'h3C);
      rd_chk(15'h200E, 8'h00);
      rd_chk(15'h000D, 8'h00);
      $display("test ram done");
   endtask
   task automatic t_cmd();
      wr(15'h000B, 8'hFF);
      rd_chk(15'h000B, 8'hFC);
      wr(15'h000B, 8'hC4);
      $display("test cmd done");
   endtask
   task automatic t_power();
      wr(15'h0010, 8'h11);
      vcc <= 1'b0;
      repeat (4) @(posedge clk);
      wr(15'h0010, 8'h5A);
      brw_host_inst.rd(15'h0010, v, ok);
      `BRW_CHK("drive while supply bad", 1'b0, ok)
      vcc <= 1'b1;
      brw_host_inst.rd(15'h0010, v, ok);
      `BRW_CHK("drive before stable", 1'b0, ok)
      repeat (PWR + 8) @(posedge clk);
      rd_chk(15'h0010, 8'h11);
      $display("test power done");
   endtask
   task automatic t_time();
      wr(15'h0000, 8'h00);
      ticks(12);
      rd_chk(15'h0000, 8'h12);
      wr(15'h000B, 8'h44);
      ticks(6);
      rd_chk(15'h0000, 8'h12);
      wr(15'h000B, 8'hC4);
      ticks(2);
      rd_chk(15'h0000, 8'h20);
      wr(15'h0009, 8'h81);
      ticks(3);
      rd_chk(15'h0000, 8'h20);
      wr(15'h0009, 8'h01);
      $display("test time done");
   endtask
   task automatic t_rollover(input logic [7:0] yr, input logic [7:0] edate, input logic [7:0] emon);
      wr(15'h000A, yr);
      wr(15'h0009, 8'h02);
      wr(15'h0008, 8'h28);
      wr(15'h0006, 8'h07);
      wr(15'h0004, 8'h71);
      wr(15'h0002, 8'h59);
      wr(15'h0001, 8'h59);
      wr(15'h0000, 8'h99);
      ticks(1);
      rd_chk(15'h0004, 8'h52);
      rd_chk(15'h0002, 8'h00);
      rd_chk(15'h0006, 8'h01);
      rd_chk(15'h0008, edate);
      rd_chk(15'h0009, emon);
      $display("test rollover done");
   endtask
   task automatic t_watchdog();
      rd_chk(15'h0003, 8'h00);
      wr(15'h000C, 8'h03);
      wr(15'h000D, 8'h00);
      vcc <= 1'b0;
      ticks(2);
      `BRW_CHK("watchdog irq early", 1'b1, irq_b)
      ticks(1);
      `BRW_CHK("watchdog irq", 1'b0, irq_b)
      vcc <= 1'b1;
      repeat (PWR + 8) @(posedge clk);
      rd_chk(15'h000B, 8'hC6);
      wr(15'h000B, 8'h84);
      `BRW_CHK("watchdog on first irq", 1'b0, irq_a_n)
      `BRW_CHK("alarm on second irq", 1'b1, irq_b)
      wr(15'h000B, 8'hC4);
      rd_chk(15'h000C, 8'h03);
      `BRW_CHK("watchdog irq cleared", 1'b1, irq_b)
      `BRW_CHK("alarm irq", 1'b1, irq_a_n)
      wr(15'h000C, 8'h00);
      $display("test watchdog done");
   endtask
   task automatic t_alarm();
      int lows;
      wr(15'h000B, 8'hC0);
      wr(15'h0003, 8'h80);
      wr(15'h0005, 8'h80);
      wr(15'h0007, 8'h80);
      wr(15'h0001, 8'h59);
      wr(15'h0000, 8'h99);
      ticks(1);
      `BRW_CHK("alarm irq level", 1'b0, irq_a_n)
      rd_chk(15'h000B, 8'hC1);
      rd_chk(15'h0007, 8'h80);
      `BRW_CHK("alarm irq cleared", 1'b1, irq_a_n)
      wr(15'h000B, 8'hD0);
      wr(15'h0001, 8'h59);
      wr(15'h0000, 8'h99);
      lows = a_low;
      ticks(1);
      `BRW_CHK("alarm pulse cycles", PULSE, a_low - lows)
      rd_chk(15'h000B, 8'hD1);
      $display("test alarm done");
   endtask
   initial begin
      nrst_n = 1'b0;
      vcc = 1'b1;
      osc = 1'b0;
      repeat (16) @(posedge clk);
      nrst_n <= 1'b1;
      repeat (PWR + 8) @(posedge clk);
      t_reset_regs();
      t_ram();
      t_cmd();
      t_power();
      t_time();
      t_rollover(8'h23, 8'h01, 8'h03);
      t_rollover(8'h24, 8'h29, 8'h02);
      t_watchdog();
      t_alarm();
      finish_test();
   end
   initial begin
      repeat (100000) @(posedge clk);
      err_total++;
      $display("wrong value run time expected end seen hang");
      finish_test();
   end
endmodule
`default_nettype wire
